// File: hw/ivc_axil_slave.sv
// axi4-lite slave front end turning bus transfers into register strobes
// assumes the core answers register reads combinationally in the strobe cycle
`timescale 1ns/10ps
`default_nettype none
`include "ivc_map.svh"

module ivc_axil_slave #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // axi4-lite
  input wire ivc_pkg::ivc_axil_req_t axi_req,
  output ivc_pkg::ivc_axil_rsp_t axi_rsp,
  // register side
  output ivc_pkg::ivc_reg_acc_t acc,
  input wire ivc_pkg::ivc_reg_rsp_t rsp
);
  import ivc_pkg::*;

  ivc_slave_state_t s_r, s_nxt;

  // ------------------------------------------------------------
  // strobes
  // ------------------------------------------------------------
  always_comb begin
    acc.wr_en = s_r.aw_held && s_r.w_held && !s_r.bvalid;
    acc.waddr = s_r.awaddr;
    acc.wdata = s_r.wdata;
    acc.wstrb = s_r.wstrb;
    acc.rd_en = axi_req.arvalid && !s_r.rvalid;
    acc.raddr = axi_req.araddr[ADDR_W-1:0];
  end

  // ------------------------------------------------------------
  // channel state
  // ------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    if (axi_req.awvalid && !s_r.aw_held) begin
      s_nxt.aw_held = 1'b1;
      s_nxt.awaddr = axi_req.awaddr[ADDR_W-1:0];
    end
    if (axi_req.wvalid && !s_r.w_held) begin
      s_nxt.w_held = 1'b1;
      s_nxt.wdata = axi_req.wdata;
      s_nxt.wstrb = axi_req.wstrb;
    end
    if (acc.wr_en) begin
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = rsp.wr_err ? `IVC_RESP_SLVERR : `IVC_RESP_OKAY;
    end
    // holding slots free only once the response is taken, one write in flight
    if (s_r.bvalid && axi_req.bready) begin
      s_nxt.bvalid = 1'b0;
      s_nxt.aw_held = 1'b0;
      s_nxt.w_held = 1'b0;
    end
    if (acc.rd_en) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata = rsp.rdata;
      s_nxt.rresp = rsp.rd_err ? `IVC_RESP_SLVERR : `IVC_RESP_OKAY;
    end else if (s_r.rvalid && axi_req.rready) begin
      s_nxt.rvalid = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  always_comb begin
    axi_rsp.awready = !s_r.aw_held;
    axi_rsp.wready = !s_r.w_held;
    axi_rsp.bvalid = s_r.bvalid;
    axi_rsp.bresp = s_r.bresp;
    axi_rsp.arready = !s_r.rvalid;
    axi_rsp.rvalid = s_r.rvalid;
    axi_rsp.rdata = s_r.rdata;
    axi_rsp.rresp = s_r.rresp;
  end

endmodule
`default_nettype wire

// File: hw/ivc_core.sv
// interrupt vector controller tail: spurious vector, debug control, fast forcing
// assumes level sources synchronous to ref_clk and an axi4-lite master
//
// Overview of operation
// - spurious vector register, read-write, resets zero
// - spurious normal vector read returns spurious value
// - spurious fast vector read returns spurious value
// - debug bit 0 enables protection mode
// - debug bit 1 holds both lines inactive
// - fast-force set writes ones to enable
// - fast-force clear writes ones to disable
// - fast-force state reads enabled sources
// - fast forcing only on bits 1 to 31
// - core status shows both lines active
// - any write to end-of-handling ends service
`timescale 1ns/10ps
`default_nettype none
`include "ivc_map.svh"

module ivc_core (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // register bus
  input wire ivc_pkg::ivc_axil_req_t axi_req,
  output ivc_pkg::ivc_axil_rsp_t axi_rsp,
  // interrupt sources, bit 0 is the fast source
  input wire logic [31:0] src_in,
  // processor lines, active low
  output logic normal_irq_out_n,
  output logic fast_irq_out_n
);
  import ivc_pkg::*;

  ivc_core_state_t s_r, s_nxt;
  ivc_reg_acc_t acc;
  ivc_reg_rsp_t rsp;
  logic [31:0] pend;
  logic [31:0] forced;
  logic [31:0] norm_cand;
  logic fast_req;
  logic norm_req;
  logic [4:0] norm_idx;
  logic rd_norm;
  logic wr_norm;
  logic ack;
  logic protection_mode_bit;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // highest source number wins among normal candidates
  function automatic logic [4:0] hi_index(input logic [31:0] v);
    logic [4:0] idx;
    idx = `IVC_RST_IDX;
    for (int i = 0; i < 32; i++) begin
      if (v[i]) begin
        idx = i[4:0];
      end
    end
    return idx;
  endfunction

  function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] d,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // ------------------------------------------------------------
  // bus slave
  // ------------------------------------------------------------
  ivc_axil_slave #(
    .ADDR_W(8)
  ) u_slave (
    .ref_clk(ref_clk),
    .rst(rst),
    .axi_req(axi_req),
    .axi_rsp(axi_rsp),
    .acc(acc),
    .rsp(rsp)
  );

  // ------------------------------------------------------------
  // source routing
  // ------------------------------------------------------------
  always_comb begin
    protection_mode_bit = s_r.dbg[`IVC_DBG_PROTECTION_MODE_BIT];
    pend = src_in & s_r.enable;
    forced = pend & s_r.ff & `IVC_FF_MASK;
    fast_req = pend[`IVC_FAST_SRC] || (|forced);
    norm_cand = pend & ~s_r.ff & `IVC_FF_MASK;
    norm_req = (|norm_cand) && !s_r.in_service;
    norm_idx = hi_index(norm_cand);
    rd_norm = acc.rd_en && (acc.raddr == `IVC_OFF_NORMAL_VEC);
    wr_norm = acc.wr_en && (acc.waddr == `IVC_OFF_NORMAL_VEC);
    // reading acknowledges only outside protection mode, so a debugger can peek safely
    ack = norm_req && ((rd_norm && !protection_mode_bit) || (wr_norm && protection_mode_bit));
  end

  // ------------------------------------------------------------
  // register writes and line state
  // ------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    if (acc.wr_en) begin
      case (acc.waddr)
        `IVC_OFF_VEC_BASE: begin
          s_nxt.vec_base = merge_strb(s_r.vec_base, acc.wdata, acc.wstrb);
        end
        `IVC_OFF_SRC_ENABLE: begin
          s_nxt.enable = merge_strb(s_r.enable, acc.wdata, acc.wstrb);
        end
        `IVC_OFF_SPURIOUS: begin
          s_nxt.spurious = merge_strb(s_r.spurious, acc.wdata, acc.wstrb);
        end
        `IVC_OFF_DEBUG_CTRL: begin
          if (acc.wstrb[0]) begin
            s_nxt.dbg = acc.wdata[`IVC_DBG_GLOBAL_MASK_BIT:`IVC_DBG_PROTECTION_MODE_BIT];
          end
        end
        `IVC_OFF_FF_SET: begin
          s_nxt.ff = s_r.ff | (acc.wdata & `IVC_FF_MASK);
        end
        `IVC_OFF_FF_CLEAR: begin
          s_nxt.ff = s_r.ff & ~(acc.wdata & `IVC_FF_MASK);
        end
        `IVC_OFF_EOI: begin
          s_nxt.in_service = 1'b0;
        end
        default: begin
          s_nxt.ff = s_r.ff;
        end
      endcase
    end
    // acknowledge after the end-of-handling clear, so a same-cycle set wins
    if (ack) begin
      s_nxt.in_service = 1'b1;
      s_nxt.cur_src = norm_idx;
    end
    // general mask overrides everything on both lines
    s_nxt.irq_n = !((|norm_cand) && !s_nxt.in_service && !s_nxt.dbg[`IVC_DBG_GLOBAL_MASK_BIT]);
    s_nxt.fiq_n = !(fast_req && !s_nxt.dbg[`IVC_DBG_GLOBAL_MASK_BIT]);
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_r.vec_base <= `IVC_RST_WORD;
      s_r.enable <= `IVC_RST_WORD;
      s_r.spurious <= `IVC_RST_WORD;
      s_r.dbg <= `IVC_RST_DBG;
      s_r.ff <= `IVC_RST_WORD;
      s_r.in_service <= 1'b0;
      s_r.cur_src <= `IVC_RST_IDX;
      s_r.irq_n <= 1'b1;
      s_r.fiq_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ------------------------------------------------------------
  // register reads
  // ------------------------------------------------------------
  always_comb begin
    rsp.rdata = `IVC_RST_WORD;
    rsp.rd_err = 1'b0;
    case (acc.raddr)
      `IVC_OFF_VEC_BASE: begin
        rsp.rdata = s_r.vec_base;
      end
      `IVC_OFF_SRC_ENABLE: begin
        rsp.rdata = s_r.enable;
      end
      `IVC_OFF_NORMAL_VEC: begin
        // spurious when no candidate is left or one is already in service
        rsp.rdata = norm_req ? (s_r.vec_base + {25'h000_0000, norm_idx, `IVC_VEC_SHIFT})
                             : s_r.spurious;
      end
      `IVC_OFF_FAST_VEC: begin
        rsp.rdata = fast_req ? s_r.vec_base : s_r.spurious;
      end
      `IVC_OFF_CORE_STATUS: begin
        rsp.rdata[`IVC_CORE_NORMAL] = !s_r.irq_n;
        rsp.rdata[`IVC_CORE_FAST] = !s_r.fiq_n;
      end
      `IVC_OFF_SPURIOUS: begin
        rsp.rdata = s_r.spurious;
      end
      `IVC_OFF_DEBUG_CTRL: begin
        rsp.rdata[`IVC_DBG_GLOBAL_MASK_BIT:`IVC_DBG_PROTECTION_MODE_BIT] = s_r.dbg;
      end
      `IVC_OFF_FF_STATE: begin
        rsp.rdata = s_r.ff & `IVC_FF_MASK;
      end
      `IVC_OFF_EOI, `IVC_OFF_FF_SET, `IVC_OFF_FF_CLEAR: begin
        rsp.rdata = `IVC_RST_WORD;
      end
      default: begin
        rsp.rd_err = 1'b1;
      end
    endcase
    // write-only and read-only offsets are mapped; only holes give an error
    case (acc.waddr)
      `IVC_OFF_VEC_BASE, `IVC_OFF_SRC_ENABLE, `IVC_OFF_NORMAL_VEC, `IVC_OFF_FAST_VEC,
      `IVC_OFF_CORE_STATUS, `IVC_OFF_EOI, `IVC_OFF_SPURIOUS, `IVC_OFF_DEBUG_CTRL,
      `IVC_OFF_FF_SET, `IVC_OFF_FF_CLEAR, `IVC_OFF_FF_STATE: begin
        rsp.wr_err = 1'b0;
      end
      default: begin
        rsp.wr_err = 1'b1;
      end
    endcase
  end

  assign normal_irq_out_n = s_r.irq_n;
  assign fast_irq_out_n = s_r.fiq_n;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  a_spu_reset_zero: assert property ($fell(rst) |-> s_r.spurious == `IVC_RST_WORD)
    else $error("spurious vector not zero after reset");

  a_spu_normal_read: assert property (rd_norm && !norm_req |-> ##1 axi_rsp.rvalid
    && axi_rsp.rdata == $past(s_r.spurious))
    else $error("spurious normal vector read wrong");

  a_spu_fast_read: assert property (acc.rd_en && acc.raddr == `IVC_OFF_FAST_VEC && !fast_req
    |=> axi_rsp.rdata == $past(s_r.spurious))
    else $error("spurious fast vector read wrong");

  a_protection_mode_bit_bit_write: assert property (acc.wr_en && acc.waddr == `IVC_OFF_DEBUG_CTRL && acc.wstrb[0]
    |=> protection_mode_bit == $past(acc.wdata[`IVC_DBG_PROTECTION_MODE_BIT]))
    else $error("protection bit not written");

  a_global_mask_bit_quiet_lines: assert property (s_r.dbg[`IVC_DBG_GLOBAL_MASK_BIT] && $stable(s_r.dbg)
    |-> normal_irq_out_n && fast_irq_out_n)
    else $error("line active under general mask");

  a_ff_set_bits: assert property (acc.wr_en && acc.waddr == `IVC_OFF_FF_SET
    |=> (s_r.ff & $past(acc.wdata) & `IVC_FF_MASK) == ($past(acc.wdata) & `IVC_FF_MASK)
    && (s_r.ff & ~$past(acc.wdata)) == ($past(s_r.ff) & ~$past(acc.wdata)))
    else $error("fast force set wrong");

  a_ff_clear_bits: assert property (acc.wr_en && acc.waddr == `IVC_OFF_FF_CLEAR
    |=> (s_r.ff & $past(acc.wdata)) == 32'h0000_0000
    && (s_r.ff & ~$past(acc.wdata)) == ($past(s_r.ff) & ~$past(acc.wdata)))
    else $error("fast force clear wrong");

  a_ff_bit_zero: assert property (acc.rd_en && acc.raddr == `IVC_OFF_FF_STATE
    |=> axi_rsp.rdata[`IVC_FAST_SRC] == 1'b0 && axi_rsp.rdata == ($past(s_r.ff) & `IVC_FF_MASK))
    else $error("fast force state read wrong");

  a_core_line_status: assert property (acc.rd_en && acc.raddr == `IVC_OFF_CORE_STATUS
    |=> axi_rsp.rdata[1:0] == {!$past(normal_irq_out_n), !$past(fast_irq_out_n)})
    else $error("core status mismatch");

  a_eoi_ends_service: assert property (acc.wr_en && acc.waddr == `IVC_OFF_EOI && !ack
    |=> !s_r.in_service)
    else $error("end of handling ignored");

  a_forced_to_fast: assert property ((|forced) && !s_r.dbg[`IVC_DBG_GLOBAL_MASK_BIT]
    && $stable(s_r.dbg) |=> !fast_irq_out_n || $past(acc.wr_en))
    else $error("forced source not on fast line");

  a_protection_mode_bit_read_quiet: assert property (rd_norm && protection_mode_bit && !wr_norm
    |=> s_r.in_service == $past(s_r.in_service) && s_r.cur_src == $past(s_r.cur_src))
    else $error("protected read changed state");

  a_protection_mode_bit_write_ack: assert property (wr_norm && protection_mode_bit && norm_req |=> s_r.in_service)
    else $error("protected write did not acknowledge");

  a_ack_source_latch: assert property (ack |=> s_r.cur_src == $past(norm_idx))
    else $error("acknowledged source not latched");

  a_ack_line_drop: assert property (ack |=> normal_irq_out_n)
    else $error("normal line still active after acknowledge");

  a_fast_vec_value: assert property (acc.rd_en && acc.raddr == `IVC_OFF_FAST_VEC && fast_req
    |=> axi_rsp.rdata == $past(s_r.vec_base))
    else $error("fast vector read wrong");

  a_spu_word_write: assert property (acc.wr_en && acc.waddr == `IVC_OFF_SPURIOUS && (&acc.wstrb)
    |=> s_r.spurious == $past(acc.wdata))
    else $error("spurious vector write lost");

  a_fast_line_follow: assert property (fast_req && !s_r.dbg[`IVC_DBG_GLOBAL_MASK_BIT] && !acc.wr_en
    |=> !fast_irq_out_n)
    else $error("fast request not on fast line");

endmodule
`default_nettype wire

// File: hw/ivc_map.svh
// register offsets, field positions and reset values of the interrupt vector controller
// assumes a 32-bit AXI4-Lite register bus decoding the low eight address bits
`ifndef IVC_MAP_SVH
`define IVC_MAP_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define IVC_OFF_VEC_BASE 8'h00
`define IVC_OFF_SRC_ENABLE 8'h04
`define IVC_OFF_NORMAL_VEC 8'h08
`define IVC_OFF_FAST_VEC 8'h0C
`define IVC_OFF_CORE_STATUS 8'h10
`define IVC_OFF_EOI 8'h14
`define IVC_OFF_SPURIOUS 8'h18
`define IVC_OFF_DEBUG_CTRL 8'h1C
`define IVC_OFF_FF_SET 8'h20
`define IVC_OFF_FF_CLEAR 8'h24
`define IVC_OFF_FF_STATE 8'h28

// ------------------------------------------------------------
// fields and reset values
// ------------------------------------------------------------
`define IVC_DBG_PROTECTION_MODE_BIT 0
`define IVC_DBG_GLOBAL_MASK_BIT 1
`define IVC_CORE_FAST 0
`define IVC_CORE_NORMAL 1
`define IVC_FAST_SRC 0
`define IVC_FF_MASK 32'hFFFF_FFFE
`define IVC_RST_WORD 32'h0000_0000
`define IVC_RST_DBG 2'h0
`define IVC_RST_IDX 5'h00
`define IVC_RESP_OKAY 2'h0
`define IVC_RESP_SLVERR 2'h2
`define IVC_VEC_SHIFT 2'h0

`endif

// File: hw/ivc_pkg.sv
// types shared by the interrupt vector controller and its bus slave
// assumes nothing beyond a SystemVerilog compiler
package ivc_pkg;

  // ------------------------------------------------------------
  // axi4-lite channels, protection_mode_bit signals left out
  // ------------------------------------------------------------
  typedef struct packed {
    logic awvalid;
    logic [31:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [31:0] araddr;
    logic rready;
  } ivc_axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ivc_axil_rsp_t;

  // ------------------------------------------------------------
  // register access strobes between slave and core
  // ------------------------------------------------------------
  typedef struct packed {
    logic wr_en;
    logic [7:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic rd_en;
    logic [7:0] raddr;
  } ivc_reg_acc_t;

  typedef struct packed {
    logic [31:0] rdata;
    logic rd_err;
    logic wr_err;
  } ivc_reg_rsp_t;

  // ------------------------------------------------------------
  // module state
  // ------------------------------------------------------------
  typedef struct packed {
    logic aw_held;
    logic [7:0] awaddr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ivc_slave_state_t;

  typedef struct packed {
    logic [31:0] vec_base;
    logic [31:0] enable;
    logic [31:0] spurious;
    logic [1:0] dbg;
    logic [31:0] ff;
    logic in_service;
    logic [4:0] cur_src;
    logic irq_n;
    logic fiq_n;
  } ivc_core_state_t;

endpackage

// File: tb/ivc_core_test.sv
// testbench of the vector controller tail: bus tasks, row table, line scenarios
// assumes ivc_core answers over axi4-lite and drives active-low lines
`timescale 1ns/10ps
`default_nettype none
`include "ivc_map.svh"

module ivc_core_test;
  import ivc_pkg::*;

  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0] wa;
    logic [31:0] wd;
    logic [1:0] wr;
    logic [7:0] ra;
    logic [31:0] rd;
    logic [1:0] rr;
  } ivc_row_t;

  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  ivc_axil_req_t axi_req = '0;
  ivc_axil_rsp_t axi_rsp;
  logic [31:0] src_in = 32'h0000_0000;
  logic normal_irq_out_n;
  logic fast_irq_out_n;
  logic normal_act;
  logic fast_act;
  logic [7:0] normal_takes;
  int err_count = 0;
  int cmp_count = 0;

  ivc_row_t rows [10] = '{
    '{8'h18, 32'h1234_5670, 2'h0, 8'h18, 32'h1234_5670, 2'h0},
    '{8'h20, 32'hFFFF_FFFF, 2'h0, 8'h28, 32'hFFFF_FFFE, 2'h0},
    '{8'h24, 32'h0000_00F1, 2'h0, 8'h28, 32'hFFFF_FF0E, 2'h0},
    '{8'h24, 32'hFFFF_FFFF, 2'h0, 8'h28, 32'h0000_0000, 2'h0},
    '{8'h1C, 32'h0000_0003, 2'h0, 8'h1C, 32'h0000_0003, 2'h0},
    '{8'h1C, 32'h0000_0000, 2'h0, 8'h1C, 32'h0000_0000, 2'h0},
    '{8'h00, 32'h0000_1000, 2'h0, 8'h00, 32'h0000_1000, 2'h0},
    '{8'h2C, 32'h5555_5555, 2'h2, 8'h2C, 32'h0000_0000, 2'h2},
    '{8'h28, 32'hFFFF_FFFF, 2'h0, 8'h28, 32'h0000_0000, 2'h0},
    '{8'h20, 32'h0000_0001, 2'h0, 8'h28, 32'h0000_0000, 2'h0}
  };

  always #5 ref_clk = ~ref_clk;

  ivc_core i_ivc_core (
    .ref_clk(ref_clk),
    .rst(rst),
    .axi_req(axi_req),
    .axi_rsp(axi_rsp),
    .src_in(src_in),
    .normal_irq_out_n(normal_irq_out_n),
    .fast_irq_out_n(fast_irq_out_n)
  );

  ivc_cpu_model i_ivc_cpu_model (
    .ref_clk(ref_clk),
    .rst(rst),
    .normal_irq_out_n(normal_irq_out_n),
    .fast_irq_out_n(fast_irq_out_n),
    .normal_act(normal_act),
    .fast_act(fast_act),
    .normal_takes(normal_takes)
  );

  // ------------------------------------------------------------
  // compare and bus tasks
  // ------------------------------------------------------------
  task automatic chk_w(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_r(input string n, input logic [1:0] e, input logic [1:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_l(input string n, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %b seen %b", n, e, g);
    end
  endtask

  // address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_p;
    logic w_p;
    aw_p = 1'b1;
    w_p = 1'b1;
    @(posedge ref_clk);
    axi_req.awvalid <= 1'b1;
    axi_req.awaddr <= {24'h00_0000, a};
    axi_req.wvalid <= 1'b1;
    axi_req.wdata <= d;
    axi_req.wstrb <= 4'hF;
    axi_req.bready <= 1'b1;
    while (aw_p || w_p) begin
      @(posedge ref_clk);
      if (aw_p && axi_rsp.awready === 1'b1) begin
        aw_p = 1'b0;
        axi_req.awvalid <= 1'b0;
      end
      if (w_p && axi_rsp.wready === 1'b1) begin
        w_p = 1'b0;
        axi_req.wvalid <= 1'b0;
      end
    end
    do @(posedge ref_clk); while (axi_rsp.bvalid !== 1'b1);
    r = axi_rsp.bresp;
    axi_req.bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    axi_req.arvalid <= 1'b1;
    axi_req.araddr <= {24'h00_0000, a};
    axi_req.rready <= 1'b1;
    do @(posedge ref_clk); while (axi_rsp.arready !== 1'b1);
    axi_req.arvalid <= 1'b0;
    do @(posedge ref_clk); while (axi_rsp.rvalid !== 1'b1);
    d = axi_rsp.rdata;
    r = axi_rsp.rresp;
    axi_req.rready <= 1'b0;
  endtask

  task automatic wrc(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    chk_r("bresp", `IVC_RESP_OKAY, r);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    chk_w("rdata", e, d);
    chk_r("rresp", `IVC_RESP_OKAY, r);
  endtask

  // lines move one edge after a source, debug or end-of-handling change, two after an enable or forcing write; three edges leave margin
  task automatic lines(input logic n, input logic f);
    repeat (3) @(posedge ref_clk);
    chk_l("normal line", n, normal_act);
    chk_l("fast line", f, fast_act);
    rdc(`IVC_OFF_CORE_STATUS, {30'h0, n, f});
  endtask

  task automatic stop_test();
    if (err_count == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    stop_test();
  end

  initial begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    rdc(`IVC_OFF_SPURIOUS, `IVC_RST_WORD);
    rdc(`IVC_OFF_DEBUG_CTRL, `IVC_RST_WORD);
    rdc(`IVC_OFF_FF_STATE, `IVC_RST_WORD);
    lines(1'b0, 1'b0);
    for (int i = 0; i < 10; i++) begin
      axi_wr(rows[i].wa, rows[i].wd, r);
      chk_r("row bresp", rows[i].wr, r);
      axi_rd(rows[i].ra, d, r);
      chk_w("row rdata", rows[i].rd, d);
      chk_r("row rresp", rows[i].rr, r);
    end
    // nothing pending: both vectors give the spurious value
    rdc(`IVC_OFF_NORMAL_VEC, 32'h1234_5670);
    rdc(`IVC_OFF_FAST_VEC, 32'h1234_5670);
    wrc(`IVC_OFF_EOI, 32'h0000_0000);
    wrc(`IVC_OFF_SRC_ENABLE, 32'hFFFF_FFFF);
    src_in <= 32'h0000_0020;
    lines(1'b1, 1'b0);
    rdc(`IVC_OFF_NORMAL_VEC, 32'h0000_1014);
    lines(1'b0, 1'b0);
    rdc(`IVC_OFF_NORMAL_VEC, 32'h1234_5670);
    wrc(`IVC_OFF_EOI, 32'hA5A5_A5A5);
    lines(1'b1, 1'b0);
    chk_w("takes", 32'h2, {24'h0, normal_takes});
    // forcing moves the source to the fast line
    wrc(`IVC_OFF_FF_SET, 32'h0000_0020);
    lines(1'b0, 1'b1);
    rdc(`IVC_OFF_FAST_VEC, 32'h0000_1000);
    wrc(`IVC_OFF_DEBUG_CTRL, 32'h0000_0002);
    lines(1'b0, 1'b0);
    wrc(`IVC_OFF_DEBUG_CTRL, 32'h0000_0000);
    lines(1'b0, 1'b1);
    wrc(`IVC_OFF_FF_CLEAR, 32'h0000_0020);
    lines(1'b1, 1'b0);
    // protection: a read leaves the line, a write acknowledges
    wrc(`IVC_OFF_DEBUG_CTRL, 32'h0000_0001);
    rdc(`IVC_OFF_NORMAL_VEC, 32'h0000_1014);
    lines(1'b1, 1'b0);
    wrc(`IVC_OFF_NORMAL_VEC, 32'h0000_0000);
    lines(1'b0, 1'b0);
    wrc(`IVC_OFF_EOI, 32'hFFFF_FFFF);
    lines(1'b1, 1'b0);
    src_in <= 32'h0000_0000;
    lines(1'b0, 1'b0);
    stop_test();
  end
endmodule

`default_nettype wire

// File: tb/ivc_cpu_model.sv
// processor side model: decodes the two active-low request lines
// assumes both lines are registered in the ref_clk domain
`timescale 1ns/10ps
`default_nettype none

module ivc_cpu_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // processor lines
  input wire logic normal_irq_out_n,
  input wire logic fast_irq_out_n,
  // decoded view
  output logic normal_act,
  output logic fast_act,
  output logic [7:0] normal_takes
);
  // ------------------------------------------------------------
  // line decode
  // ------------------------------------------------------------
  logic last_n_r;

  // active low: a core sees a request while the line is low
  assign normal_act = !normal_irq_out_n;
  assign fast_act = !fast_irq_out_n;

  // count normal line falling edges, a core enters its handler once per edge
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      last_n_r <= 1'b1;
      normal_takes <= 8'h00;
    end else begin
      last_n_r <= normal_irq_out_n;
      if (last_n_r && !normal_irq_out_n) begin
        normal_takes <= normal_takes + 8'h01;
      end
    end
  end
endmodule

`default_nettype wire
